// >>> bench/analog_front_model.sv
// Purpose: comparator front end and current-peak source beside the charger supervisor
// Assumes: analog quantities arrive as integer millivolts and ohms from the bench
// Notes: cur_peak fires peak_cycles after the high-side gate turns on; 0 means never
`timescale 1ns/1ps
module analog_front_model
import chg_pkg::*;
#(
    parameter int ADAPTER_MV = 4000
) (
    input wire logic hclk,
    input wire logic high_side_gate,
    input wire logic [31:0] ohms,
    input wire logic [31:0] adapter_mv,
    input wire logic [31:0] cell_stack_voltage_mv,
    input wire logic [31:0] peak_cycles,
    output cmp_t cmp
);
    logic [31:0] on_cnt;
    always_ff @(posedge hclk) begin
        on_cnt <= high_side_gate ? on_cnt + 1 : 32'h0;
    end
    always_comb begin
        cmp.temp_open = ohms > 100000;
        cmp.temp_cold = ohms > 30000;
        cmp.temp_hot = ohms < 3000;
        cmp.temp_short = ohms < 500;
        cmp.src_rise = adapter_mv >= cell_stack_voltage_mv + 300;
        cmp.src_fall = adapter_mv <= cell_stack_voltage_mv + 100;
        cmp.load_off = adapter_mv + 100 >= cell_stack_voltage_mv;
        cmp.load_on = adapter_mv + 300 <= cell_stack_voltage_mv;
        cmp.adapter = adapter_mv >= ADAPTER_MV;
        cmp.cur_peak = peak_cycles != 0 && on_cnt >= peak_cycles;
    end
endmodule : analog_front_model

// >>> bench/test_charger_monitor_control.sv
// Purpose: self-checking bench for the charger supervisor
// Assumes: ON_MAX shortened to 200 cycles; bus is the only software path
// Notes: bench tasks act as the bus master, which starts every transfer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module test_charger_monitor_control;
import chg_pkg::*;
logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, alert_n;
logic high_side_gate, low_side_gate, source_switch_drive, load_switch_drive;
logic [31:0] haddr, hwdata, hrdata, ohms, adapter_mv, cell_stack_voltage_mv, peak_cycles, seed, d;
logic [1:0] htrans;
logic [2:0] hsize;
logic [3:0] cell_stack_voltage;
cmp_t cmp_in;
setpoint_t setpoint;
int bad_count, num_checks, overlap, on_c, off_c, gap;
bit s, src_m, load_m, ac_m, ps, pa, hot_m;
logic [7:0] ra[5] = '{A_MODE, A_CUR, A_VOLT, A_IRQM, 8'h1c};
logic [31:0] re[5] = '{32'h2, 32'h80, 32'h4800, 32'h0, 32'h0};
int av[8] = '{12200, 12350, 12150, 12050, 11950, 11650, 11800, 12400};
int to[5] = '{40000, 10000, 2000, 450, 10000};
logic [15:0] cv[3] = '{16'h0bc1, 16'h007f, 16'h0bc0};
logic [15:0] vv[3] = '{16'h03f0, 16'h4800, 16'h0400};
assign hready = hreadyout;
charger_monitor_control #(.ON_MAX(200)) i_charger_monitor_control (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .cmp_in(cmp_in),
    .cell_stack_voltage(cell_stack_voltage), .setpoint(setpoint), .high_side_gate(high_side_gate),
    .low_side_gate(low_side_gate), .source_switch_drive(source_switch_drive),
    .load_switch_drive(load_switch_drive), .alert_n(alert_n), .irq(irq));
analog_front_model i_analog_front_model (.hclk(hclk), .high_side_gate(high_side_gate), .ohms(ohms),
    .adapter_mv(adapter_mv), .cell_stack_voltage_mv(cell_stack_voltage_mv), .peak_cycles(peak_cycles), .cmp(cmp_in));
////////////////////////////////////////////////////////////////////////////////
initial begin
    hclk = 1'b0;
    forever #4 hclk = ~hclk;
end
always @(posedge hclk) begin
    if (high_side_gate === 1'b1 && low_side_gate === 1'b1) overlap++;
end
initial begin
    repeat (60000) @(posedge hclk);
    bad_count++;
    conclude();
end
////////////////////////////////////////////////////////////////////////////////
task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask : conclude
task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rdat = hrdata;
    `CHK("hresp", 1'b0, hresp)
endtask : bus
task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    bus(a, 1'b1, wd, x);
endtask : wr
task automatic rd(input logic [7:0] a, output logic [31:0] rdat);
    bus(a, 1'b0, 32'h0, rdat);
endtask : rd
task automatic settle();
    repeat (6) @(posedge hclk);
    #1;
endtask : settle
task automatic gate_seen(output bit seen);
    seen = 1'b0;
    repeat (700) begin
        @(posedge hclk);
        if (high_side_gate === 1'b1) seen = 1'b1;
    end
endtask : gate_seen
task automatic measure(output int on_n, output int off_n);
    int n;
    n = 0;
    on_n = 0;
    off_n = 0;
    while (high_side_gate === 1'b1 && n < 3000) begin @(posedge hclk); n++; end
    while (high_side_gate !== 1'b1 && n < 3000) begin @(posedge hclk); n++; end
    while (high_side_gate === 1'b1 && n < 3000) begin @(posedge hclk); n++; on_n++; end
    while (high_side_gate !== 1'b1 && n < 3000) begin
        @(posedge hclk);
        n++;
        off_n++;
        if (low_side_gate !== !high_side_gate) gap++;
    end
endtask : measure
function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
endfunction : rnd
function automatic logic [16:0] clamp(logic [15:0] c, logic [15:0] v);
    logic [5:0] cc;
    logic [10:0] vv;
    cc = (c < 16'h0080) ? 6'h0 : (c > 16'h0bc0) ? 6'h2f : c[11:6];
    vv = (v < 16'h0400) ? 11'h0 : (v >= 16'h4800) ? 11'h480 : v[14:4];
    return {vv, cc};
endfunction : clamp
////////////////////////////////////////////////////////////////////////////////
initial begin
    logic [15:0] c, v;
    seed = 32'd53;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    ohms = 10000;
    adapter_mv = 0;
    cell_stack_voltage_mv = 12000;
    peak_cycles = 0;
    cell_stack_voltage = 4'hf;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    foreach (ra[i]) begin rd(ra[i], d); `CHK("reset reg", re[i], d) end
    `CHK("reset setpoint", {11'h480, 6'h02}, setpoint)
    rd(A_IRQS, d);
    settle();
    `CHK("irq idle", 1'b0, irq)
    $display("test reset done");
    src_m = 1'b0;
    load_m = 1'b1;
    ac_m = 1'b0;
    foreach (av[i]) begin
        @(posedge hclk);
        adapter_mv <= av[i];
        ps = src_m;
        pa = ac_m;
        if (av[i] >= 12300) src_m = 1'b1; else if (av[i] <= 12100) src_m = 1'b0;
        if (av[i] >= 11900) load_m = 1'b0; else if (av[i] <= 11700) load_m = 1'b1;
        ac_m = av[i] >= 4000;
        settle();
        `CHK("source", src_m, source_switch_drive)
        `CHK("load", load_m, load_switch_drive)
        `CHK("irq", (src_m != ps) || (ac_m != pa), irq)
        `CHK("alert_n", !((src_m != ps) || (ac_m != pa)), alert_n)
        rd(A_IRQS, d);
        `CHK("pf event", src_m != ps, d[0])
        rd(A_STAT, d);
        `CHK("pf flag", !src_m, d[ST_PF])
        `CHK("src flag", src_m, d[ST_SRC])
    end
    wr(A_IRQM, 32'h1);
    @(posedge hclk);
    adapter_mv <= 12050;
    settle();
    `CHK("masked irq", 1'b0, irq)
    wr(A_IRQM, 32'h0);
    @(posedge hclk);
    adapter_mv <= 12400;
    settle();
    `CHK("unmasked irq", 1'b1, irq)
    rd(A_IRQS, d);
    $display("test switches done");
    hot_m = 1'b0;
    foreach (to[i]) begin
        @(posedge hclk);
        ohms <= to[i];
        hot_m |= to[i] < 3000;
        settle();
        rd(A_STAT, d);
        `CHK("temp flags", {to[i] > 100000, to[i] < 500, hot_m, to[i] > 30000}, d[3:0])
        gate_seen(s);
        `CHK("gate", !hot_m, s)
    end
    wr(A_MODE, 32'h0);
    gate_seen(s);
    `CHK("halt off", 1'b1, s)
    rd(A_STAT, d);
    `CHK("hot latched", 1'b1, d[ST_HOT])
    wr(A_MODE, 32'h3);
    settle();
    rd(A_STAT, d);
    `CHK("hot restore", 1'b0, d[ST_HOT])
    wr(A_CUR, 32'h0400);
    @(posedge hclk);
    ohms <= 200000;
    settle();
    rd(A_STAT, d);
    `CHK("open", 2'b01, {d[ST_PACK], d[ST_OPEN]})
    rd(A_CUR, d);
    `CHK("open cur", 32'h80, d)
    @(posedge hclk);
    ohms <= 10000;
    settle();
    rd(A_IRQS, d);
    `CHK("pack event", 1'b1, d[1])
    $display("test thermal done");
    measure(on_c, off_c);
    `CHK("on max", 1'b1, on_c >= 198 && on_c <= 202)
    `CHK("off 15", 1'b1, off_c >= 123 && off_c <= 127)
    @(posedge hclk);
    cell_stack_voltage <= 4'h3;
    measure(on_c, off_c);
    measure(on_c, off_c);
    `CHK("off 3", 1'b1, off_c >= 498 && off_c <= 502)
    @(posedge hclk);
    peak_cycles <= 20;
    measure(on_c, off_c);
    `CHK("peak on", 1'b1, on_c >= 20 && on_c < 40)
    `CHK("overlap", 0, overlap)
    `CHK("low gate", 0, gap)
    $display("test gate done");
    wr(A_ALARM, 32'h0800);
    settle();
    rd(A_STAT, d);
    `CHK("inhibit", 1'b1, d[ST_INHIB])
    gate_seen(s);
    `CHK("inhibit gate", 1'b0, s)
    for (int i = 0; i < 6; i++) begin
        c = (i < 3) ? cv[i] : rnd() >> 16;
        v = (i < 3) ? vv[i] : rnd() >> 16;
        wr(A_CUR, {16'h0, c});
        wr(A_VOLT, {16'h0, v});
        settle();
        rd(A_STAT, d);
        `CHK("inhibit clear", 1'b0, d[ST_INHIB])
        `CHK("setpoint", clamp(c, v), setpoint)
    end
    $display("test setpoints done");
    conclude();
end
endmodule : test_charger_monitor_control

// >>> rtl/charger_monitor_control.sv
// Purpose: thermal flags, power switch drives, gate timing and register access of a charger
// Assumes: comparators are asynchronous; cell_stack_voltage is a level code on hclk
// Notes: single clock, zero-wait AHB-Lite slave, level interrupt plus active-low alert
//
// Chosen here: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
module charger_monitor_control #(
    parameter int ON_MAX = chg_pkg::ON_MAX_CYC
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire chg_pkg::cmp_t cmp_in,
    input wire logic [3:0] cell_stack_voltage,
    output chg_pkg::setpoint_t setpoint,
    output logic high_side_gate,
    output logic low_side_gate,
    output logic source_switch_drive,
    output logic load_switch_drive,
    output logic alert_n,
    output logic irq
);
    import chg_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // comparator synchronisers: change accepted once stages two and three agree
    logic [NCMP-1:0] raw;
    logic [NCMP-1:0] s1_q, s2_q, s3_q, stab_q;
    cmp_t f;
    assign raw = cmp_in;
    assign f = stab_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            stab_q <= '0;
        end else begin
            s1_q <= raw;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (int i = 0; i < NCMP; i++) begin
                if (s2_q[i] == s3_q[i]) begin
                    stab_q[i] <= s3_q[i];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // bus slave: zero wait states, always OKAY; the block never masters
    logic ap_q, wr_q;
    logic [7:0] ad_q;
    logic ap;
    logic wr_cmd;
    logic [15:0] wd;
    assign ap = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign wr_cmd = ap_q && wr_q;
    assign wd = hwdata[15:0];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ap_q <= 1'b0;
            wr_q <= 1'b0;
            ad_q <= 8'h00;
        end else begin
            ap_q <= ap;
            wr_q <= hwrite;
            ad_q <= {haddr[7:2], 2'b00};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mode, setpoint and alarm registers
    logic [15:0] mode_q, cur_q, volt_q;
    logic [2:0] irqm_q;
    logic restore, removed, hot_q, inhib_q, got_cur_q, got_volt_q, pack_q;
    assign restore = wr_cmd && ad_q == A_MODE && wd[M_RESTORE];
    assign removed = f.temp_open;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= MODE_RST;
            cur_q <= CUR_RST;
            volt_q <= VOLT_RST;
            irqm_q <= IRQM_RST;
        end else if (removed || restore) begin
            mode_q <= MODE_RST;
            cur_q <= CUR_RST;
            volt_q <= VOLT_RST;
            irqm_q <= IRQM_RST;
        end else if (wr_cmd) begin
            case (ad_q)
                A_MODE: mode_q <= wd & ~16'h0001;
                A_CUR: cur_q <= wd;
                A_VOLT: volt_q <= wd;
                A_IRQM: irqm_q <= wd[2:0];
                default: ;
            endcase
        end
    end

    // alarm inhibit: set by a terminating warning, cleared by removal,
    // restore, or fresh current and voltage words; set wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            inhib_q <= 1'b0;
            got_cur_q <= 1'b0;
            got_volt_q <= 1'b0;
        end else if (wr_cmd && ad_q == A_ALARM && (wd & ALARM_TERM) != 16'h0000) begin
            inhib_q <= 1'b1;
            got_cur_q <= 1'b0;
            got_volt_q <= 1'b0;
        end else if (removed || restore || (got_cur_q && got_volt_q)) begin
            inhib_q <= 1'b0;
            got_cur_q <= 1'b0;
            got_volt_q <= 1'b0;
        end else if (wr_cmd && ad_q == A_CUR) begin
            got_cur_q <= 1'b1;
        end else if (wr_cmd && ad_q == A_VOLT) begin
            got_volt_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // temperature flags; each comparator feeds its own flag
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hot_q <= 1'b0;
            pack_q <= 1'b0;
        end else begin
            if (f.temp_hot) begin
                hot_q <= 1'b1;
            end else if (removed || restore) begin
                hot_q <= 1'b0;
            end
            pack_q <= !f.temp_open;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // source and load switches with hysteresis
    logic src_q, load_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            src_q <= 1'b0;
            load_q <= 1'b1;
        end else begin
            if (f.src_rise) begin
                src_q <= 1'b1;
            end else if (f.src_fall) begin
                src_q <= 1'b0;
            end
            if (f.load_on) begin
                load_q <= 1'b1;
            end else if (f.load_off) begin
                load_q <= 1'b0;
            end
        end
    end
    assign source_switch_drive = src_q;
    assign load_switch_drive = load_q;

    ////////////////////////////////////////////////////////////////////////////
    // regulated setpoints with overrange clamps
    setpoint_t sp_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_q <= '0;
        end else begin
            if (cur_q < CUR_MIN) begin
                sp_q.cur_code <= 6'h00;
            end else if (cur_q > CUR_MAX) begin
                sp_q.cur_code <= CUR_MAX[11:6];
            end else begin
                sp_q.cur_code <= cur_q[11:6];
            end
            if (volt_q < VOLT_MIN) begin
                sp_q.volt_code <= 11'h000;
            end else if (volt_q >= VOLT_MAX) begin
                sp_q.volt_code <= VOLT_MAX[14:4];
            end else begin
                sp_q.volt_code <= volt_q[14:4];
            end
        end
    end
    assign setpoint = sp_q;

    ////////////////////////////////////////////////////////////////////////////
    // gate timing: on until peak current or maximum on-time, then off-time of OFF_CYC * OFF_STEPS / (cell_stack_voltage + 1) cycles
    typedef enum logic [1:0] {S_IDLE, S_ON, S_OFF} gate_t;
    gate_t st_q, st_d;
    logic [31:0] cnt_q, cnt_d, off_len;
    logic run, high_q, low_q;

    assign run = pack_q && !inhib_q && !(hot_q && mode_q[M_HALT])
        && src_q
        && sp_q.cur_code != 6'h00 && sp_q.volt_code != 11'h000;
    assign off_len = (OFF_CYC * OFF_STEPS) / (32'(cell_stack_voltage) + 32'd1);

    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        case (st_q)
            S_IDLE: begin
                cnt_d = 32'd0;
                if (run) begin
                    st_d = S_ON;
                end
            end
            S_ON: begin
                if (!run || f.cur_peak || cnt_q >= 32'(ON_MAX - 1)) begin
                    st_d = S_OFF;
                    cnt_d = off_len - 32'd1;
                end else begin
                    cnt_d = cnt_q + 32'd1;
                end
            end
            S_OFF: begin
                if (cnt_q == 32'd0) begin
                    st_d = run ? S_ON : S_IDLE;
                end else begin
                    cnt_d = cnt_q - 32'd1;
                end
            end
            default: begin
                st_d = S_IDLE;
                cnt_d = 32'd0;
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_q <= S_IDLE;
            cnt_q <= 32'd0;
            high_q <= 1'b0;
            low_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            high_q <= st_d == S_ON;
            low_q <= st_d == S_OFF;
        end
    end
    assign high_side_gate = high_q;
    assign low_side_gate = low_q;

    ////////////////////////////////////////////////////////////////////////////
    // status word and interrupt events
    logic [15:0] stat;
    logic [2:0] ev_now, ev_q, irqs_q;
    logic rd_irqs;
    always_comb begin
        stat = 16'h0000;
        stat[ST_COLD] = f.temp_cold;
        stat[ST_HOT] = hot_q;
        stat[ST_SHORT] = f.temp_short;
        stat[ST_OPEN] = f.temp_open;
        stat[ST_INHIB] = inhib_q;
        stat[ST_RUN] = run;
        stat[ST_SRC] = src_q;
        stat[ST_LOAD] = load_q;
        stat[ST_PF] = !src_q;
        stat[ST_PACK] = pack_q;
        stat[ST_AC] = f.adapter;
    end
    assign ev_now = {stat[ST_AC], stat[ST_PACK], stat[ST_PF]};
    assign rd_irqs = ap && !hwrite && haddr[7:0] == A_IRQS;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            // power fail stands during reset, so no false power-fail change follows release
            ev_q <= 3'h1;
            irqs_q <= 3'h0;
        end else begin
            ev_q <= ev_now;
            // any register write or an A_IRQS read clears; a new change wins
            irqs_q <= ((rd_irqs || wr_cmd) ? 3'h0 : irqs_q) | (ev_now ^ ev_q);
        end
    end
    assign irq = |(irqs_q & ~irqm_q);
    assign alert_n = !irq;

    ////////////////////////////////////////////////////////////////////////////
    // read data, registered at the end of the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (ap && !hwrite) begin
            case (haddr[7:0])
                A_MODE: hrdata <= {16'h0000, mode_q};
                A_CUR: hrdata <= {16'h0000, cur_q};
                A_VOLT: hrdata <= {16'h0000, volt_q};
                A_STAT: hrdata <= {16'h0000, stat};
                A_IRQS: hrdata <= {29'h0, irqs_q};
                A_IRQM: hrdata <= {29'h0, irqm_q};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    logic [31:0] on_run_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            on_run_q <= 32'd0;
        end else begin
            on_run_q <= high_q ? on_run_q + 32'd1 : 32'd0;
        end
    end

    sequence s_alarm_wr;
        ap && hwrite && haddr[7:0] == A_ALARM ##1 (hwdata[15:11] != 5'h00);
    endsequence

    property p_open_defaults;
        @(posedge hclk) disable iff (!hresetn) f.temp_open |=> !pack_q && cur_q == CUR_RST && !hot_q;
    endproperty
    a_open_defaults: assert property (p_open_defaults) else $error("open sense kept state");

    property p_hot_latch;
        @(posedge hclk) disable iff (!hresetn) hot_q && !f.temp_open && !restore |=> hot_q;
    endproperty
    a_hot_latch: assert property (p_hot_latch) else $error("overheat flag dropped");

    property p_hot_halt;
        @(posedge hclk) disable iff (!hresetn) hot_q && mode_q[M_HALT] |=> !high_q;
    endproperty
    a_hot_halt: assert property (p_hot_halt) else $error("gate on while overheated");

    property p_src_cause;
        @(posedge hclk) disable iff (!hresetn) $rose(src_q) |-> $past(f.src_rise);
    endproperty
    a_src_cause: assert property (p_src_cause) else $error("source on without rise");

    property p_pf_gate;
        @(posedge hclk) disable iff (!hresetn) !src_q |=> !high_q;
    endproperty
    a_pf_gate: assert property (p_pf_gate) else $error("gate on during power fail");

    property p_load_on;
        @(posedge hclk) disable iff (!hresetn) f.load_on |=> load_q;
    endproperty
    a_load_on: assert property (p_load_on) else $error("load switch not on");

    property p_on_max;
        @(posedge hclk) disable iff (!hresetn) on_run_q <= 32'(ON_MAX);
    endproperty
    a_on_max: assert property (p_on_max) else $error("on period too long");

    property p_alarm;
        @(posedge hclk) disable iff (!hresetn) s_alarm_wr |=> inhib_q ##1 !high_q;
    endproperty
    a_alarm: assert property (p_alarm) else $error("alarm not inhibiting");

    property p_alert;
        @(posedge hclk) disable iff (!hresetn) (ev_now ^ ev_q) != 3'h0 |=> (irqs_q & (ev_q ^ $past(ev_q))) != 3'h0;
    endproperty
    a_alert: assert property (p_alert) else $error("status change lost");

endmodule : charger_monitor_control

// >>> rtl/chg_pkg.sv
// Purpose: shared constants and types for the charger supervisor
// Assumes: 125 MHz hclk, 32-bit AHB-Lite register access
// Notes: offsets are byte addresses of aligned words
package chg_pkg;
    localparam logic [7:0] A_MODE = 8'h00;
    localparam logic [7:0] A_CUR = 8'h04;
    localparam logic [7:0] A_VOLT = 8'h08;
    localparam logic [7:0] A_ALARM = 8'h0c;
    localparam logic [7:0] A_STAT = 8'h10;
    localparam logic [7:0] A_IRQS = 8'h14;
    localparam logic [7:0] A_IRQM = 8'h18;
    localparam logic [15:0] CUR_RST = 16'h0080;
    localparam logic [15:0] VOLT_RST = 16'h4800;
    localparam logic [15:0] CUR_MIN = 16'h0080;
    localparam logic [15:0] CUR_MAX = 16'h0bc0;
    localparam logic [15:0] VOLT_MIN = 16'h0400;
    localparam logic [15:0] VOLT_MAX = 16'h4800;
    localparam logic [15:0] ALARM_TERM = 16'hf800;
    localparam logic [15:0] MODE_RST = 16'h0002;
    localparam int M_RESTORE = 0;
    localparam int M_HALT = 1;
    localparam logic [2:0] IRQM_RST = 3'h0;
    localparam int ST_COLD = 0;
    localparam int ST_HOT = 1;
    localparam int ST_SHORT = 2;
    localparam int ST_OPEN = 3;
    localparam int ST_INHIB = 4;
    localparam int ST_RUN = 5;
    localparam int ST_SRC = 6;
    localparam int ST_LOAD = 7;
    localparam int ST_PF = 13;
    localparam int ST_PACK = 14;
    localparam int ST_AC = 15;
    localparam int CLK_MHZ = 125;
    localparam int ON_MAX_MS = 10;
    localparam int ON_MAX_CYC = ON_MAX_MS * 1000 * CLK_MHZ;
    localparam int OFF_TIME_NS = 1000;
    localparam int OFF_CYC = (OFF_TIME_NS * CLK_MHZ) / 1000;
    localparam int OFF_STEPS = 16;
    localparam int NCMP = 10;
    // asynchronous comparator decisions from the analog front end
    typedef struct packed {
        logic temp_open;
        logic temp_cold;
        logic temp_hot;
        logic temp_short;
        logic src_rise;
        logic src_fall;
        logic load_off;
        logic load_on;
        logic adapter;
        logic cur_peak;
    } cmp_t;
    typedef struct packed {
        logic [10:0] volt_code;
        logic [5:0] cur_code;
    } setpoint_t;
endpackage : chg_pkg
